// ==== shared/cpp_pin_map.svh ====
`ifndef CPP_PIN_MAP_SVH
`define CPP_PIN_MAP_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CPP_CLK_NS       10
`define CPP_BOOT_QTR_NS  1250
`define CPP_STRAP_WAIT   2'h3

// ------------------------------------------------------------
// Addressing and frame layout
// ------------------------------------------------------------
`define CPP_I2C_ADDR_HI  5'h0E
`define CPP_SPI_SEL_BIT  1
`define CPP_RW_BIT       0
`define CPP_BOOT_DEV     7'h50
`define CPP_BYTE_CHIP    2'h0
`define CPP_BYTE_AHI     2'h1
`define CPP_BYTE_ALO     2'h2
`define CPP_BYTE_DATA    2'h3

// ------------------------------------------------------------
// Output clock half periods in system clocks
// ------------------------------------------------------------
`define CPP_CKDIV0       4'h1
`define CPP_CKDIV1       4'h2
`define CPP_CKDIV2       4'h4
`define CPP_CKDIV3       4'h8

`endif

// ==== shared/cpp_pkg.sv ====
package cpp_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CPP_I_IDLE,
		CPP_I_RX,
		CPP_I_ACK,
		CPP_I_TX,
		CPP_I_RACK
	} cpp_i2c_e;

	typedef enum logic [2:0] {
		CPP_B_IDLE,
		CPP_B_START,
		CPP_B_ADDR,
		CPP_B_AACK,
		CPP_B_READ,
		CPP_B_MACK,
		CPP_B_STOP,
		CPP_B_DONE
	} cpp_boot_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} cpp_wr_s;

endpackage

// ==== rtl/cpp_sync.sv ====
`timescale 1ns/1ps
module cpp_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_chk
		$error("cpp_sync needs at least one bit");
	end

	// Only the second stage may read the first.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// ==== rtl/cpp_clk_out.sv ====
`timescale 1ns/1ps
`include "cpp_pin_map.svh"
module cpp_clk_out
	import cpp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic [1:0] sel,
	output logic            clk_out
);
	logic [3:0] half;
	logic [3:0] cnt_r;
	logic [1:0] sel_d_r;

	always_comb begin
		if (sel == 2'h0) begin
			half = `CPP_CKDIV0;
		end else if (sel == 2'h1) begin
			half = `CPP_CKDIV1;
		end else if (sel == 2'h2) begin
			half = `CPP_CKDIV2;
		end else begin
			half = `CPP_CKDIV3;
		end
	end

	// A change of selection restarts the count so no runt half period is stretched past the new one.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_r   <= 4'h0;
			sel_d_r <= 2'h0;
			clk_out <= 1'b0;
		end else begin
			sel_d_r <= sel;
			if (sel_d_r != sel || cnt_r == half - 4'h1) begin
				cnt_r   <= 4'h0;
				clk_out <= ~clk_out;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end

	chk_div_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
		(sel_d_r == sel) |-> (cnt_r < half)) else $error("output clock divider overran");
endmodule

// ==== rtl/cpp_pin_logic.sv ====
`timescale 1ns/1ps
`include "cpp_pin_map.svh"
module cpp_pin_logic
	import cpp_pkg::*;
#(
	parameter logic [15:0] BOOT_LEN = 16'h0010
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        four_wire_mode,
	input  wire logic        addr_sel_low,
	input  wire logic        addr_sel_high,
	input  wire logic        transaction_latch_n,
	input  wire logic        boot_select,
	input  wire logic        out_clk_sel0,
	input  wire logic        out_clk_sel1,
	input  wire logic        clock_i,
	output logic             clock_o,
	output logic             clock_oe,
	input  wire logic        data_i,
	output logic             data_o,
	output logic             data_oe,
	output logic             master_clock_out,
	output logic             wr_valid,
	output cpp_wr_s          wr_req,
	output logic             rd_req,
	output logic      [15:0] rd_addr,
	input  wire logic [7:0]  rd_data,
	output logic             boot_valid,
	output logic      [7:0]  boot_data,
	output logic             boot_busy,
	output logic             boot_error
);
	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam int          QTR_CYC = `CPP_BOOT_QTR_NS / `CPP_CLK_NS;
	localparam logic [9:0]  QTR_END = 10'(QTR_CYC - 1);

	if (BOOT_LEN == 16'h0000 || QTR_CYC < 8 || QTR_CYC > 1023) begin : g_chk
		$error("cpp_pin_logic: boot length or quarter period out of range");
	end

	// ------------------------------------------------------------
	// Pin synchronisers and straps
	// ------------------------------------------------------------
	logic [7:0] s_pins;
	logic       s_scl, s_sda, s_latch, s_din, s_a0, s_boot;
	logic [1:0] s_ck;
	logic       scl_d_r, sda_d_r;
	logic [1:0] strap_cnt_r;
	logic       strap_ok_r, addr_low_r, addr_high_r, boot_r;

	cpp_sync #(.W(8)) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.din     ({clock_i, data_i, transaction_latch_n, addr_sel_high,
		            addr_sel_low, boot_select, out_clk_sel1, out_clk_sel0}),
		.dout    (s_pins)
	);
	assign {s_scl, s_sda, s_latch, s_din, s_a0, s_boot, s_ck} = s_pins;

	// Straps are caught a few clocks after release, once the synchroniser has settled.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strap_cnt_r <= 2'h0;
			strap_ok_r  <= 1'b0;
			addr_low_r  <= 1'b0;
			addr_high_r <= 1'b0;
			boot_r      <= 1'b0;
		end else if (!strap_ok_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `CPP_STRAP_WAIT) begin
				strap_ok_r  <= 1'b1;
				addr_low_r  <= s_a0;
				addr_high_r <= s_din;
				boot_r      <= s_boot;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= s_scl;
			sda_d_r <= s_sda;
		end
	end

	// ------------------------------------------------------------
	// Shared byte receiver
	// ------------------------------------------------------------
	cpp_i2c_e   ist_r;
	cpp_boot_e  bst_r;
	logic       boot_act, spi_on, i2c_on, frame, rise, fall, start, stop;
	logic       rx_rise, byte_done, i2c_match, spi_sel, i2c_next;
	logic [7:0] byte_v, sh_r;
	logic [2:0] bit_cnt_r;
	logic [1:0] byte_cnt_r;
	logic       rd_r, sel_ok_r, rd_active_r, rd_ack_r, wr_valid_r, rd_req_r;
	logic [15:0] addr_r;
	cpp_wr_s    wr_r;

	assign boot_act  = bst_r != CPP_B_IDLE && bst_r != CPP_B_DONE;
	assign spi_on    = strap_ok_r && four_wire_mode && !boot_act;
	assign i2c_on    = strap_ok_r && !four_wire_mode && !boot_act;
	assign frame     = spi_on && !s_latch;
	assign rise      = s_scl && !scl_d_r;
	assign fall      = !s_scl && scl_d_r;
	assign start     = i2c_on && s_scl && scl_d_r && sda_d_r && !s_sda;
	assign stop      = i2c_on && s_scl && scl_d_r && !sda_d_r && s_sda;
	assign rx_rise   = rise && (frame || (i2c_on && ist_r == CPP_I_RX));
	assign byte_done = rx_rise && bit_cnt_r == 3'h7;
	assign byte_v    = {sh_r[6:0], frame ? s_din : s_sda};
	assign i2c_match = byte_v[7:1] == {`CPP_I2C_ADDR_HI, addr_high_r, addr_low_r};
	assign spi_sel   = byte_v[`CPP_SPI_SEL_BIT] == addr_low_r;
	assign i2c_next  = i2c_on && rise && ist_r == CPP_I_RACK && !s_sda;

	// In two-wire mode the frame layout after the first byte is decided by its read/write bit, so length varies.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sh_r        <= 8'h00;
			bit_cnt_r   <= 3'h0;
			byte_cnt_r  <= `CPP_BYTE_CHIP;
			rd_r        <= 1'b0;
			sel_ok_r    <= 1'b0;
			rd_active_r <= 1'b0;
			rd_ack_r    <= 1'b0;
			rd_req_r    <= 1'b0;
			wr_valid_r  <= 1'b0;
			addr_r      <= 16'h0000;
			wr_r        <= '0;
		end else begin
			wr_valid_r <= 1'b0;
			rd_req_r   <= i2c_next;
			rd_ack_r   <= rd_req_r;
			if (rd_ack_r) begin
				addr_r <= addr_r + 16'h0001;
			end
			if ((spi_on && s_latch) || start || stop || !strap_ok_r) begin
				bit_cnt_r   <= 3'h0;
				byte_cnt_r  <= `CPP_BYTE_CHIP;
				rd_active_r <= 1'b0;
				sel_ok_r    <= 1'b0;
			end else if (rx_rise) begin
				sh_r      <= byte_v;
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (byte_done) begin
					case (byte_cnt_r)
						`CPP_BYTE_CHIP: begin
							sel_ok_r <= frame ? spi_sel : i2c_match;
							rd_r     <= byte_v[`CPP_RW_BIT];
							if (!frame && byte_v[`CPP_RW_BIT]) begin
								byte_cnt_r  <= `CPP_BYTE_DATA;
								rd_active_r <= i2c_match;
								rd_req_r    <= i2c_match;
							end else begin
								byte_cnt_r <= `CPP_BYTE_AHI;
							end
						end
						`CPP_BYTE_AHI: begin
							addr_r[15:8] <= byte_v;
							byte_cnt_r   <= `CPP_BYTE_ALO;
						end
						`CPP_BYTE_ALO: begin
							addr_r[7:0] <= byte_v;
							byte_cnt_r  <= `CPP_BYTE_DATA;
							if (frame && rd_r && sel_ok_r) begin
								rd_active_r <= 1'b1;
								rd_req_r    <= 1'b1;
							end
						end
						default: begin
							if (!rd_r && sel_ok_r) begin
								wr_valid_r <= 1'b1;
								wr_r       <= '{addr: addr_r, data: byte_v};
								addr_r     <= addr_r + 16'h0001;
							end else if (frame && rd_active_r) begin
								rd_req_r <= 1'b1;
							end
						end
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Slave output side: two-wire acknowledge and read, four-wire read
	// ------------------------------------------------------------
	logic [7:0] out_sh_r;
	logic       out_r, sda_low_r, ack_pend_r;
	logic [2:0] tx_cnt_r;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ist_r      <= CPP_I_IDLE;
			sda_low_r  <= 1'b0;
			ack_pend_r <= 1'b0;
			tx_cnt_r   <= 3'h0;
			out_sh_r   <= 8'h00;
			out_r      <= 1'b0;
		end else begin
			if (rd_ack_r) begin
				out_sh_r <= rd_data;
			end else if (frame && rd_active_r && fall) begin
				out_r    <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
			if (!spi_on) begin
				out_r <= 1'b0;
			end
			if (!i2c_on || stop) begin
				ist_r      <= CPP_I_IDLE;
				sda_low_r  <= 1'b0;
				ack_pend_r <= 1'b0;
			end else if (start) begin
				ist_r      <= CPP_I_RX;
				sda_low_r  <= 1'b0;
				ack_pend_r <= 1'b0;
			end else begin
				case (ist_r)
					CPP_I_RX: begin
						if (byte_done) begin
							ack_pend_r <= (byte_cnt_r != `CPP_BYTE_CHIP) || i2c_match;
						end else if (fall && ack_pend_r) begin
							sda_low_r  <= 1'b1;
							ack_pend_r <= 1'b0;
							ist_r      <= CPP_I_ACK;
						end else if (fall && bit_cnt_r == 3'h0 && byte_cnt_r == `CPP_BYTE_AHI && !sel_ok_r) begin
							ist_r <= CPP_I_IDLE;
						end
					end
					CPP_I_ACK: begin
						if (fall) begin
							tx_cnt_r <= 3'h0;
							if (rd_active_r) begin
								sda_low_r <= ~out_sh_r[7];
								out_sh_r  <= {out_sh_r[6:0], 1'b0};
								ist_r     <= CPP_I_TX;
							end else begin
								sda_low_r <= 1'b0;
								ist_r     <= CPP_I_RX;
							end
						end
					end
					CPP_I_TX: begin
						if (fall) begin
							sda_low_r <= ~out_sh_r[7];
							out_sh_r  <= {out_sh_r[6:0], 1'b0};
						end else if (rise) begin
							tx_cnt_r <= tx_cnt_r + 3'h1;
							if (tx_cnt_r == 3'h7) begin
								ist_r <= CPP_I_RACK;
							end
						end
					end
					CPP_I_RACK: begin
						if (fall) begin
							sda_low_r <= 1'b0;
						end else if (rise) begin
							tx_cnt_r <= 3'h0;
							ist_r    <= s_sda ? CPP_I_IDLE : CPP_I_TX;
						end
					end
					default: ist_r <= CPP_I_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Self-boot master
	// ------------------------------------------------------------
	logic [9:0]  bcnt_r;
	logic [1:0]  bq_r;
	logic [2:0]  bbit_r;
	logic [7:0]  bsh_r;
	logic [15:0] blen_r;
	logic        mscl_low_r, msda_low_r, bvalid_r, berr_r;
	logic [7:0]  bdata_r;

	// Each bit takes four quarter periods: clock low, hold, release, sample.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bst_r      <= CPP_B_IDLE;
			bcnt_r     <= 10'h000;
			bq_r       <= 2'h0;
			bbit_r     <= 3'h0;
			bsh_r      <= 8'h00;
			blen_r     <= 16'h0000;
			mscl_low_r <= 1'b0;
			msda_low_r <= 1'b0;
			bvalid_r   <= 1'b0;
			bdata_r    <= 8'h00;
			berr_r     <= 1'b0;
		end else begin
			bvalid_r <= 1'b0;
			bcnt_r   <= (bcnt_r == QTR_END) ? 10'h000 : bcnt_r + 10'h001;
			if (bst_r == CPP_B_IDLE) begin
				bq_r <= 2'h0;
				if (!strap_ok_r && strap_cnt_r == `CPP_STRAP_WAIT && s_boot) begin
					bst_r <= CPP_B_START;
				end
			end else if (bst_r != CPP_B_DONE && bcnt_r == QTR_END) begin
				bq_r <= bq_r + 2'h1;
				if (bst_r == CPP_B_START) begin
					msda_low_r <= bq_r >= 2'h2;
					if (bq_r == 2'h3) begin
						bst_r  <= CPP_B_ADDR;
						bsh_r  <= {`CPP_BOOT_DEV, 1'b1};
						bbit_r <= 3'h0;
					end
				end else if (bq_r == 2'h0) begin
					mscl_low_r <= 1'b1;
					msda_low_r <= (bst_r == CPP_B_ADDR && !bsh_r[7]) || bst_r == CPP_B_STOP ||
					              (bst_r == CPP_B_MACK && blen_r != BOOT_LEN - 16'h0001);
				end else if (bq_r == 2'h2) begin
					mscl_low_r <= 1'b0;
				end else if (bq_r == 2'h3) begin
					case (bst_r)
						CPP_B_ADDR: begin
							bsh_r  <= {bsh_r[6:0], 1'b0};
							bbit_r <= bbit_r + 3'h1;
							if (bbit_r == 3'h7) begin
								bst_r <= CPP_B_AACK;
							end
						end
						CPP_B_AACK: begin
							berr_r <= s_sda;
							bst_r  <= s_sda ? CPP_B_STOP : CPP_B_READ;
						end
						CPP_B_READ: begin
							bsh_r  <= {bsh_r[6:0], s_sda};
							bbit_r <= bbit_r + 3'h1;
							if (bbit_r == 3'h7) begin
								bvalid_r <= 1'b1;
								bdata_r  <= {bsh_r[6:0], s_sda};
								bst_r    <= CPP_B_MACK;
							end
						end
						CPP_B_MACK: begin
							blen_r <= blen_r + 16'h0001;
							bst_r  <= (blen_r == BOOT_LEN - 16'h0001) ? CPP_B_STOP : CPP_B_READ;
						end
						default: begin
							msda_low_r <= 1'b0;
							bst_r      <= CPP_B_DONE;
						end
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pins and user side
	// ------------------------------------------------------------
	cpp_clk_out u_clk_out (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.sel     (s_ck),
		.clk_out (master_clock_out)
	);

	assign clock_o    = 1'b0;
	assign clock_oe   = mscl_low_r;
	assign data_o     = out_r;
	assign data_oe    = (frame && rd_active_r) || sda_low_r || msda_low_r;
	assign wr_valid   = wr_valid_r;
	assign wr_req     = wr_r;
	assign rd_req     = rd_req_r;
	assign rd_addr    = addr_r;
	assign boot_valid = bvalid_r;
	assign boot_data  = bdata_r;
	assign boot_busy  = boot_act;
	assign boot_error = berr_r;

	chk_four_wire_read_out_tristate: assert property (@(posedge clk_sys) disable iff (!nrst)
		(spi_on && data_oe) |-> (rd_active_r && !s_latch)) else $error("serial output driven outside a read");
	chk_scl_input_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		clock_oe |-> (boot_r && boot_act)) else $error("clock pin driven outside self-boot");
	chk_sda_pull_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		!four_wire_mode |-> (data_o == 1'b0)) else $error("data line driven high in two-wire mode");
	chk_strap_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(strap_ok_r) |-> ($stable(addr_low_r) && $stable(addr_high_r) && $stable(boot_r)))
		else $error("strap value changed after capture");
	chk_addr_ack_match: assert property (@(posedge clk_sys) disable iff (!nrst)
		(ist_r == CPP_I_ACK && byte_cnt_r != `CPP_BYTE_ALO && byte_cnt_r != `CPP_BYTE_DATA
		 && $past(ist_r) == CPP_I_RX && $past(byte_cnt_r) == `CPP_BYTE_AHI) |-> sel_ok_r)
		else $error("acknowledged a foreign address");
	chk_spi_select: assert property (@(posedge clk_sys) disable iff (!nrst)
		(byte_done && frame && byte_cnt_r == `CPP_BYTE_CHIP) |=> (sel_ok_r == ($past(sh_r[0]) == addr_low_r)))
		else $error("device select not taken from first address pin");
	chk_data_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
		(frame && rise) |=> (sh_r[0] == $past(s_din))) else $error("serial input not taken from data pin");
	chk_latch_ends: assert property (@(posedge clk_sys) disable iff (!nrst)
		(spi_on && s_latch) |=> (!rd_active_r && byte_cnt_r == `CPP_BYTE_CHIP)) else $error("frame survived latch");
	chk_four_wire_read_out_data: assert property (@(posedge clk_sys) disable iff (!nrst)
		(frame && rd_active_r && fall && !rd_ack_r) |=> (data_o == $past(out_sh_r[7])))
		else $error("read-back bit not presented");
	chk_boot_start: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(strap_ok_r) |-> (boot_r == (bst_r != CPP_B_IDLE))) else $error("self-boot start wrong");
endmodule

// ==== dv/cpp_host_model.sv ====
`timescale 1ns/1ps
module cpp_host_model (
	input  wire logic clk_sys,
	input  wire logic clock_oe,
	input  wire logic data_oe,
	input  wire logic data_o,
	output logic      clock_pin,
	output logic      data_pin,
	output logic      mosi,
	output logic      latch_n
);
	// ------------------------------------------------------------
	// Wired pins
	// ------------------------------------------------------------
	logic        scl_r;
	logic        sda_r;
	logic        eep_on;
	logic        eep_sda;
	logic [15:0] eep_img;
	int          eep_f;

	// Both lines have pull-ups, so a released line reads high.
	assign clock_pin = scl_r & ~clock_oe;
	assign data_pin  = sda_r & eep_sda & ~(data_oe & ~data_o);

	initial begin
		scl_r   = 1'b1;
		sda_r   = 1'b1;
		eep_on  = 1'b0;
		eep_sda = 1'b1;
		eep_img = 16'h0000;
		eep_f   = 0;
		mosi    = 1'b0;
		latch_n = 1'b1;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// Four-wire host
	// ------------------------------------------------------------
	// The clock is gated and rests high between frames.
	task automatic spi_open();
		latch_n = 1'b0;
		gap(8);
	endtask

	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			scl_r = 1'b0;
			mosi  = tx[i];
			gap(8);
			scl_r = 1'b1;
			// A released output reads as the inverse of its last bit, so a missing drive is caught.
			rx[i] = data_oe ? data_o : ~data_o;
			gap(8);
		end
	endtask

	// The data line is inverted after a frame so a stale bit is never trusted.
	task automatic spi_close();
		gap(4);
		latch_n = 1'b1;
		mosi    = ~mosi;
		gap(16);
	endtask

	// ------------------------------------------------------------
	// Two-wire host
	// ------------------------------------------------------------
	task automatic i2c_start();
		sda_r = 1'b1;
		scl_r = 1'b1;
		gap(8);
		sda_r = 1'b0;
		gap(8);
		scl_r = 1'b0;
		gap(8);
	endtask

	task automatic i2c_bit(input logic b, output logic seen);
		sda_r = b;
		gap(8);
		scl_r = 1'b1;
		gap(4);
		seen  = data_pin;
		gap(4);
		scl_r = 1'b0;
		gap(8);
	endtask

	task automatic i2c_byte(input logic [7:0] tx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(tx[i], s);
		end
		i2c_bit(1'b1, s);
		ack = ~s;
	endtask

	task automatic i2c_stop();
		sda_r = 1'b0;
		gap(8);
		scl_r = 1'b1;
		gap(8);
		sda_r = 1'b1;
		gap(16);
	endtask

	// The host releases the line for every data bit and refuses the byte so the slave stops.
	task automatic i2c_rd(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(1'b1, d[i]);
		end
		i2c_bit(1'b1, s);
	endtask

	// ------------------------------------------------------------
	// Boot memory
	// ------------------------------------------------------------
	// The memory counts clock falls from the start and moves its line only while the clock is low.
	always @(negedge clock_pin) begin
		if (eep_on) begin
			eep_f++;
			if (eep_f == 9) begin
				eep_sda <= 1'b0;
			end else if (eep_f >= 10 && eep_f <= 17) begin
				eep_sda <= eep_img[25 - eep_f];
			end else if (eep_f >= 19 && eep_f <= 26) begin
				eep_sda <= eep_img[26 - eep_f];
			end else begin
				eep_sda <= 1'b1;
			end
		end
	end
endmodule

// ==== dv/test_cpp_pin_logic.sv ====
`timescale 1ns/1ps
`include "cpp_pin_map.svh"
module test_cpp_pin_logic
	import cpp_pkg::*;
;
	logic        clk_sys, nrst, four_wire_mode, addr_sel_low, addr_sel_high, strap_hi;
	logic        boot_select, out_clk_sel0, out_clk_sel1, clock_i, clock_o, clock_oe;
	logic        data_i, data_o, data_oe, master_clock_out, wr_valid, rd_req;
	logic        boot_valid, boot_busy, boot_error, mosi, latch_n, ack, lo, hi, m0;
	logic [15:0] rd_addr, a, p, rx, bseen;
	logic [7:0]  rd_data, boot_data, d8;
	logic [6:0]  dev;
	cpp_wr_s     wr_req;
	cpp_wr_s     wq[$];
	int          err_total, samples_checked, coe_cnt, k, bv_cnt;

	assign addr_sel_high = four_wire_mode ? mosi : strap_hi;

	cpp_pin_logic #(.BOOT_LEN(16'h0002)) uut (.clk_sys(clk_sys), .nrst(nrst), .four_wire_mode(four_wire_mode),
		.addr_sel_low(addr_sel_low), .addr_sel_high(addr_sel_high), .transaction_latch_n(latch_n),
		.boot_select(boot_select), .out_clk_sel0(out_clk_sel0), .out_clk_sel1(out_clk_sel1),
		.clock_i(clock_i), .clock_o(clock_o), .clock_oe(clock_oe), .data_i(data_i), .data_o(data_o),
		.data_oe(data_oe), .master_clock_out(master_clock_out), .wr_valid(wr_valid), .wr_req(wr_req),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .boot_valid(boot_valid),
		.boot_data(boot_data), .boot_busy(boot_busy), .boot_error(boot_error));

	cpp_host_model host (.clk_sys(clk_sys), .clock_oe(clock_oe), .data_oe(data_oe), .data_o(data_o),
		.clock_pin(clock_i), .data_pin(data_i), .mosi(mosi), .latch_n(latch_n));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rd_fn(input logic [15:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h5a;
	endfunction

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bound_hit(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			give_verdict();
		end
	endtask

	task automatic do_reset(input logic boot, input logic l, input logic h, input logic fw);
		nrst           = 1'b0;
		boot_select    = boot;
		addr_sel_low   = l;
		strap_hi       = h;
		four_wire_mode = fw;
		repeat (10) @(negedge clk_sys);
		check({data_oe, clock_oe, wr_valid, clock_o}, 4'h0);
		nrst = 1'b1;
		repeat (8) @(negedge clk_sys);
		wq.delete();
	endtask

	task automatic spi_frame(input logic sel, input logic rw, input logic [15:0] ad, input logic [15:0] pl);
		logic [7:0] r;
		host.spi_open();
		host.spi_byte({5'h00, sel, rw}, r);
		host.spi_byte(ad[15:8], r);
		host.spi_byte(ad[7:0], r);
		check(data_oe, rw);
		host.spi_byte(pl[15:8], rx[15:8]);
		host.spi_byte(pl[7:0], rx[7:0]);
		host.spi_close();
	endtask

	always @(posedge clk_sys) begin
		if (wr_valid === 1'b1) begin
			wq.push_back(wr_req);
		end
		if (clock_oe === 1'b1) begin
			coe_cnt++;
		end
		if (boot_valid === 1'b1) begin
			bseen = {bseen[7:0], boot_data};
			bv_cnt++;
		end
	end

	always @(negedge clk_sys) begin
		rd_data <= rd_fn(rd_addr);
	end

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// A hung handshake still ends in the closing report.
	initial begin
		repeat (90000) @(posedge clk_sys);
		err_total++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		err_total       = 0;
		samples_checked = 0;
		coe_cnt         = 0;
		out_clk_sel0    = 1'b0;
		out_clk_sel1    = 1'b0;
		void'($urandom(61373));
		lo = 1'($urandom);
		do_reset(1'b0, lo, 1'b0, 1'b1);
		check(boot_busy, 1'b0);
		addr_sel_low = ~lo;
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 16'hffff : 16'($urandom);
			p = 16'($urandom);
			wq.delete();
			spi_frame(lo, 1'b0, a, p);
			check(wq.size(), 2);
			if (wq.size() == 2) begin
				check(wq[0], {a, p[15:8]});
				check(wq[1], {a + 16'h0001, p[7:0]});
			end
			spi_frame(lo, 1'b1, a, p);
			check(rx, {rd_fn(a), rd_fn(a + 16'h0001)});
			check(data_oe, 1'b0);
			spi_frame(~lo, 1'b0, a, p);
			check(wq.size(), 2);
		end
		for (int s = 0; s < 4; s++) begin
			{out_clk_sel1, out_clk_sel0} = 2'(s);
			repeat (40) @(negedge clk_sys);
			for (int t = 0; t < 2; t++) begin
				m0 = master_clock_out;
				for (k = 0; k < 50 && master_clock_out === m0; k++) @(negedge clk_sys);
				bound_hit(k, 50);
			end
			check(k, 1 << s);
		end
		lo = 1'($urandom);
		hi = 1'($urandom);
		do_reset(1'b0, lo, hi, 1'b0);
		addr_sel_low = ~lo;
		strap_hi     = ~hi;
		dev = {`CPP_I2C_ADDR_HI, hi, lo};
		a   = 16'($urandom);
		p   = 16'($urandom);
		host.i2c_start();
		host.i2c_byte({dev, 1'b0}, ack);
		check(ack, 1'b1);
		host.i2c_byte(a[15:8], ack);
		host.i2c_byte(a[7:0], ack);
		host.i2c_byte(p[7:0], ack);
		check(ack, 1'b1);
		host.i2c_stop();
		check(wq.size(), 1);
		if (wq.size() == 1) begin
			check(wq[0], {a, p[7:0]});
		end
		host.i2c_start();
		host.i2c_byte({dev, 1'b1}, ack);
		check(ack, 1'b1);
		host.i2c_rd(d8);
		host.i2c_stop();
		check(d8, rd_fn(a + 16'h0001));
		for (int j = 1; j < 4; j++) begin
			host.i2c_start();
			host.i2c_byte({dev ^ 7'(j), 1'b0}, ack);
			check(ack, 1'b0);
			host.i2c_stop();
		end
		check(coe_cnt, 0);
		// No memory answers here, so the boot must give up with an error.
		do_reset(1'b1, 1'b0, 1'b0, 1'b0);
		check(boot_busy, 1'b1);
		for (k = 0; k < 40000 && boot_error !== 1'b1; k++) @(negedge clk_sys);
		bound_hit(k, 40000);
		check(boot_error, 1'b1);
		check(coe_cnt > 0, 1'b1);
		// A memory now answers, so both bytes must arrive and the port must go back to slave mode.
		host.eep_img = 16'($urandom);
		host.eep_on  = 1'b1;
		bv_cnt       = 0;
		do_reset(1'b1, 1'b0, 1'b0, 1'b0);
		for (k = 0; k < 40000 && boot_busy !== 1'b0; k++) @(negedge clk_sys);
		bound_hit(k, 40000);
		check(boot_error, 1'b0);
		check(bv_cnt, 2);
		check(bseen, host.eep_img);
		give_verdict();
	end
endmodule
